// ---- logic/psm_maps.sv ----
// Purpose: skip, last-descriptor and done maps of two scan categories
// Assumes: 16-bit register port, reads return data one cycle later
// Notes: the engine holds the scan while it works on a descriptor
`timescale 1ns/1ps
`include "psm_cfg.svh"
module psm_maps
	import psm_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic reg_cs_i,
	input wire logic reg_rd_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic [15:0] per_valid_i,
	input wire logic [15:0] asy_valid_i,
	input wire logic per_hold_i,
	input wire logic asy_hold_i,
	input wire logic [15:0] per_complete_i,
	input wire logic [15:0] asy_complete_i,
	output logic [3:0] per_idx_o,
	output logic per_go_o,
	output logic per_wrap_o,
	output logic [3:0] asy_idx_o,
	output logic asy_go_o,
	output logic asy_wrap_o
);

	typedef struct packed {
		psm_cat_regs_t per;
		psm_cat_regs_t asy;
		logic [15:0] rdata;
		logic rvalid;
		psm_scan_out_t per_s;
		psm_scan_out_t asy_s;
	} psm_st_t;

	psm_st_t st_q, st_d;
	psm_scan_out_t per_sc, asy_sc;
	logic rd_hit, wr_hit;

	assign rd_hit = reg_cs_i && reg_rd_i;
	assign wr_hit = reg_cs_i && reg_wr_i;

	// ==========================================================
	// scan pointers
	psm_scan #(.N(16)) u_per_scan (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.skip_i(st_q.per.skip),
		.last_i(st_q.per.last),
		.valid_i(per_valid_i),
		.hold_i(per_hold_i),
		.scan_o(per_sc)
	);

	psm_scan #(.N(16)) u_asy_scan (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.skip_i(st_q.asy.skip),
		.last_i(st_q.asy.last),
		.valid_i(asy_valid_i),
		.hold_i(asy_hold_i),
		.scan_o(asy_sc)
	);

	// ==========================================================
	// register file
	always_comb begin
		st_d = st_q;
		st_d.rvalid = rd_hit;
		st_d.per_s = per_sc;
		st_d.asy_s = asy_sc;
		st_d.rdata = 16'h0000;
		if (rd_hit) begin
			unique case (reg_addr_i)
				`PSM_OFS_PER_DONE: st_d.rdata = st_q.per.done;
				`PSM_OFS_PER_SKIP: st_d.rdata = st_q.per.skip;
				`PSM_OFS_PER_LAST: st_d.rdata = st_q.per.last;
				`PSM_OFS_ASY_DONE: st_d.rdata = st_q.asy.done;
				`PSM_OFS_ASY_SKIP: st_d.rdata = st_q.asy.skip;
				`PSM_OFS_ASY_LAST: st_d.rdata = st_q.asy.last;
				// unmapped reads as zero
				default: st_d.rdata = 16'h0000;
			endcase
		end
		// RULE12 periodic clear-on-read
		if (rd_hit && reg_addr_i == `PSM_OFS_PER_DONE) begin
			st_d.per.done = 16'h0000;
		end
		// RULE10 async clear-on-read
		if (rd_hit && reg_addr_i == `PSM_OFS_ASY_DONE) begin
			st_d.asy.done = 16'h0000;
		end
		// RULE14 set wins over clear
		st_d.per.done = st_d.per.done | per_complete_i;
		// RULE9 completion sets bit
		st_d.asy.done = st_d.asy.done | asy_complete_i;
		// read-back is a plain register, one cycle is enough
		if (wr_hit) begin
			unique case (reg_addr_i)
				// RULE4 skip maps writable
				`PSM_OFS_PER_SKIP: st_d.per.skip = reg_wdata_i;
				`PSM_OFS_ASY_SKIP: st_d.asy.skip = reg_wdata_i;
				// RULE7 last registers writable
				`PSM_OFS_PER_LAST: st_d.per.last = reg_wdata_i;
				// RULE8 stored as one-hot marker
				`PSM_OFS_ASY_LAST: st_d.asy.last = reg_wdata_i;
				// done maps ignore writes
				default: st_d.rdata = st_d.rdata;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			// RULE4 all skipped at reset
			st_q.per.skip <= `PSM_SKIP_RST;
			st_q.asy.skip <= `PSM_SKIP_RST;
			st_q.per.last <= `PSM_LAST_RST;
			st_q.asy.last <= `PSM_LAST_RST;
			// RULE11 done starts clear
			st_q.per.done <= `PSM_DONE_RST;
			st_q.asy.done <= `PSM_DONE_RST;
			st_q.rdata <= 16'h0000;
			st_q.rvalid <= 1'b0;
			st_q.per_s <= '0;
			st_q.asy_s <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// outputs, all registered; scan view lags the pointer by one
	assign reg_rdata_o = st_q.rdata;
	assign reg_rvalid_o = st_q.rvalid;
	assign per_idx_o = st_q.per_s.idx;
	assign per_go_o = st_q.per_s.valid;
	assign per_wrap_o = st_q.per_s.wrap;
	assign asy_idx_o = st_q.asy_s.idx;
	assign asy_go_o = st_q.asy_s.valid;
	assign asy_wrap_o = st_q.asy_s.wrap;

endmodule

// ---- logic/psm_cfg.svh ----
// Purpose: constants for the descriptor scheduling map registers
// Assumes: 16-bit register port, byte offsets as printed
// Notes: every offset, reset value and timing figure lives here
//
// Operation
// RULE1: a descriptor whose skip bit is 1 is passed over even when valid.
// RULE2: software never sets a skip bit of the descriptor being processed.
// RULE3: software waits at least 100 ns after a skip map write to read it.
// RULE4: both skip maps are 16-bit read-write and reset to all ones.
// RULE5: the descriptor marked in the last register ends the valid scan.
// RULE6: after the marked descriptor the scan restarts at descriptor 0.
// RULE7: last registers are 16-bit read-write, reset to zero, 1h one, 2h two.
// RULE8: async value 4h limits the group to three, a one-hot position mark.
// RULE9: async done bits are read-only and set when a descriptor completes.
// RULE10: a done map read returns the bits and clears the ones it returned.
// RULE11: the async done map resets to zero and covers 16 descriptors.
// RULE12: the periodic done map is 16-bit read-only clear-on-read, reset 0.
// RULE13: a zero last register scans all 16; the lowest set bit ends a scan.
// RULE14: a completion in the cycle of a read stays set for the next read.
`ifndef PSM_CFG_SVH
`define PSM_CFG_SVH

// ==========================================================
// offsets
`define PSM_ADDR_W 8
`define PSM_OFS_PER_DONE 8'haa
`define PSM_OFS_PER_SKIP 8'hac
`define PSM_OFS_PER_LAST 8'hae
`define PSM_OFS_ASY_DONE 8'hb0
`define PSM_OFS_ASY_SKIP 8'hb2
`define PSM_OFS_ASY_LAST 8'hb4

// ==========================================================
// reset values
`define PSM_SKIP_RST 16'hffff
`define PSM_LAST_RST 16'h0000
`define PSM_DONE_RST 16'h0000

// ==========================================================
// timing
`define PSM_CLK_MHZ 20
`define PSM_SKIP_RD_WAIT_NS 100
`define PSM_SKIP_RD_WAIT_CYC \
	((`PSM_SKIP_RD_WAIT_NS * `PSM_CLK_MHZ + 999) / 1000)

`endif

// ---- logic/psm_pkg.sv ----
// Purpose: types for the descriptor scheduling map registers
// Assumes: psm_cfg.svh holds all numbers
// Notes: two scan categories, periodic and async
package psm_pkg;

	typedef enum logic [0:0] {
		PSM_CAT_PER = 1'b0,
		PSM_CAT_ASY = 1'b1
	} psm_cat_t;

	typedef struct packed {
		logic cs;
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [15:0] wdata;
	} psm_bus_req_t;

	typedef struct packed {
		logic [15:0] skip;
		logic [15:0] last;
		logic [15:0] done;
	} psm_cat_regs_t;

	typedef struct packed {
		logic [3:0] idx;
		logic valid;
		logic wrap;
	} psm_scan_out_t;

endpackage

// ---- logic/psm_scan.sv ----
// Purpose: one category's descriptor scan pointer
// Assumes: valid flags come from descriptor memory on the same clock
// Notes: advances one descriptor per clock while hold_i is low
`timescale 1ns/1ps
`include "psm_cfg.svh"
module psm_scan
	import psm_pkg::*;
#(
	parameter int N = 16
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [N-1:0] skip_i,
	input wire logic [N-1:0] last_i,
	input wire logic [N-1:0] valid_i,
	input wire logic hold_i,
	output psm_scan_out_t scan_o
);

	typedef struct packed {
		logic [3:0] idx;
	} psm_scan_st_t;

	psm_scan_st_t st_q, st_d;

	// ==========================================================
	// end of group
	function automatic logic is_end(input logic [N-1:0] lst,
		input logic [3:0] i);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < N; k++) begin
			// RULE13 lowest bit ends
			if (lst[k] && !hit) begin
				hit = 1'b1;
				if (k[3:0] == i) begin
					return 1'b1;
				end
			end
		end
		// RULE13 zero means all 16
		return !hit && (i == 4'(N - 1));
	endfunction

	always_comb begin
		st_d = st_q;
		scan_o.idx = st_q.idx;
		// RULE1 skip beats valid
		scan_o.valid = valid_i[st_q.idx] && !skip_i[st_q.idx];
		// RULE5 marked one is final
		scan_o.wrap = is_end(last_i, st_q.idx);
		if (!hold_i) begin
			// RULE6 restart at first
			if (scan_o.wrap) begin
				st_d.idx = 4'h0;
			end else begin
				st_d.idx = st_q.idx + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

endmodule

// ---- testbench/psm_maps_asserts.sv ----
// Purpose: port checks of the scheduling maps
// Assumes: one clock, sync active-low reset
// Notes: scan outputs lag the pointer by one cycle
`timescale 1ns/1ps
module psm_maps_chk (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic reg_cs_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire logic per_hold_i,
	input wire logic asy_hold_i,
	input wire logic [3:0] per_idx_o,
	input wire logic per_wrap_o,
	input wire logic [3:0] asy_idx_o,
	input wire logic asy_wrap_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// ==========================================
	// register port
	a_read_answer: assert property (
		reg_cs_i && reg_rd_i |=> reg_rvalid_o) else $error("no answer");
	a_no_spurious: assert property (
		!(reg_cs_i && reg_rd_i) |=> !reg_rvalid_o) else $error("stray valid");
	a_idle_zero: assert property (
		!reg_rvalid_o |-> reg_rdata_o == 16'h0000) else $error("idle data");
	a_unmapped_zero: assert property (
		reg_cs_i && reg_rd_i && !(reg_addr_i inside {8'haa, 8'hac,
		8'hae, 8'hb0, 8'hb2, 8'hb4}) |=> reg_rdata_o == 16'h0000)
		else $error("unmapped data");
	// ==========================================
	// scan pointer, hold freezes it
	a_hold_keeps: assert property (
		per_hold_i |=> ##1 $stable(per_idx_o)) else $error("hold moved");
	a_scan_steps: assert property (
		!asy_hold_i ##1 !asy_wrap_o |=> asy_idx_o == $past(asy_idx_o) + 4'h1)
		else $error("bad step");
	a_wrap_restart: assert property (
		!asy_hold_i ##1 asy_wrap_o |=> asy_idx_o == 4'h0) else $error("no wrap");
	a_per_restart: assert property (
		!per_hold_i ##1 per_wrap_o |=> per_idx_o == 4'h0) else $error("no wrap");
endmodule

bind psm_maps psm_maps_chk i_chk (.clk_sys_i, .rst_n_i, .reg_cs_i,
	.reg_rd_i, .reg_addr_i, .reg_rdata_o, .reg_rvalid_o, .per_hold_i,
	.asy_hold_i, .per_idx_o, .per_wrap_o, .asy_idx_o, .asy_wrap_o);

// ---- testbench/tb_psm_maps.sv ----
// Purpose: self-checking bench of the scheduling maps
// Assumes: read data one cycle after the read edge
// Notes: reads keep two cycles after a skip write
`timescale 1ns/1ps
module tb_psm_maps;
	logic clk_sys_i = 0, rst_n_i = 0, reg_cs_i = 0, reg_rd_i = 0, reg_wr_i = 0;
	logic per_hold_i = 0, asy_hold_i = 0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [15:0] reg_wdata_i = 16'h0, per_valid_i = 16'h8000;
	logic [15:0] asy_valid_i = 16'hfffb, per_complete_i = 16'h0;
	logic [15:0] asy_complete_i = 16'h0, reg_rdata_o;
	logic reg_rvalid_o, per_go_o, per_wrap_o, asy_go_o, asy_wrap_o;
	logic [3:0] per_idx_o, asy_idx_o;
	int mismatches = 0, tests_run = 0;
	logic [23:0] rows [7] = '{24'haa0000, 24'hacffff, 24'hae0000,
		24'hb00000, 24'hb2ffff, 24'hb40000, 24'hb60000};
	always #25 clk_sys_i = ~clk_sys_i;
	psm_maps i_dut (.clk_sys_i, .rst_n_i, .reg_cs_i, .reg_rd_i, .reg_wr_i,
		.reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
		.per_valid_i, .asy_valid_i, .per_hold_i, .asy_hold_i,
		.per_complete_i, .asy_complete_i, .per_idx_o, .per_go_o,
		.per_wrap_o, .asy_idx_o, .asy_go_o, .asy_wrap_o);
	task chk(input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		reg_cs_i <= 1'b1;
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_cs_i <= 1'b0;
		reg_wr_i <= 1'b0;
	endtask
	// completions c land in the read's own cycle
	task rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] c);
		@(posedge clk_sys_i);
		reg_cs_i <= 1'b1;
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		per_complete_i <= c;
		asy_complete_i <= c;
		@(posedge clk_sys_i);
		reg_cs_i <= 1'b0;
		reg_rd_i <= 1'b0;
		per_complete_i <= 16'h0;
		asy_complete_i <= 16'h0;
		#1;
		chk(reg_rdata_o, e);
		chk({15'h0, reg_rvalid_o}, 16'h0001);
	endtask
	task sw(input bit p);
		for (int k = 0; k < 40; k++) begin
			@(posedge clk_sys_i);
			#1;
			if ((p ? per_wrap_o : asy_wrap_o) === 1'b1) break;
		end
	endtask
	task test_done;
		$display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#(50 * 3000);
		mismatches++;
		test_done;
	end
	initial begin
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 7; i++) rd(rows[i][23:16], rows[i][15:0], 16'h0);
		wr(8'hac, 16'h1234);
		rd(8'hac, 16'h1234, 16'h0);
		wr(8'hb0, 16'hffff);
		rd(8'hb0, 16'h0000, 16'h0005);
		rd(8'hb0, 16'h0005, 16'h0100);
		rd(8'hb0, 16'h0100, 16'h0);
		rd(8'haa, 16'h0105, 16'h0);
		rd(8'haa, 16'h0000, 16'h0);
		wr(8'hac, 16'h0000);
		wr(8'hae, 16'h0030);
		rd(8'hae, 16'h0030, 16'h0);
		@(posedge clk_sys_i);
		per_hold_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		per_hold_i <= 1'b0;
		sw(1);
		sw(1);
		chk({12'h0, per_idx_o}, 16'h0004);
		wr(8'hae, 16'h0000);
		sw(1);
		sw(1);
		chk({12'h0, per_idx_o}, 16'h000f);
		chk({15'h0, per_go_o}, 16'h0001);
		// skip bit 1 and invalid bit 2 leave only descriptor 0
		// no descriptor held
		wr(8'hb2, 16'h0002);
		wr(8'hb4, 16'h0004);
		sw(0);
		sw(0);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_sys_i);
			#1;
			chk({12'h0, asy_idx_o}, 16'(i % 3));
			chk({15'h0, asy_go_o}, 16'(i % 3 == 0));
		end
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rd(8'hb2, 16'hffff, 16'h0);
		rd(8'hb4, 16'h0000, 16'h0);
		test_done;
	end
endmodule
